// ===== hw/reload_timer.sv
// Purpose: 16-bit auto-reload timer with up/down count, baud ticks and clock out
// Assumes: pins synchronous to mclk, APB master keeps the protocol
// Notes: capture mode and prescaling are not part of this block
//
// Summary of operation
// RULE1 - Direction pin high counts up, low down
// RULE2 - Up count wraps at max, sets flag, reloads
// RULE3 - Down count at reload loads max, sets flag
// RULE4 - Up/down mode toggles external flag, no request
// RULE5 - Serial select forces baud mode with reload
// RULE6 - Transmit and receive sources chosen independently
// RULE7 - Serial bit tick is overflows divided by sixteen
// RULE8 - Timer mode counts clocks, period 65536 minus reload
// RULE9 - Baud mode rollover sets no flag, no request
// RULE10 - Baud mode pin edge sets flag, no reload
// RULE11 - Clock-out mode toggles pin every rollover
// RULE12 - Clock-out rate is clock over twice period
// RULE13 - Clock-out rollovers raise no service request
// RULE14 - Baud and clock-out may run together
// RULE15 - Run control starts and stops counting
// RULE16 - Counter mode uses pin as input
// RULE17 - Counter mode counts falling pin edges
// RULE18 - Software clears external flag itself
// RULE19 - Down count enable is zero after reset
// RULE20 - Pins sampled, edges from successive samples
`timescale 1ns/100ps
module reload_timer #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic directionTriggerPin,
   input wire logic timerPinIn,
   output logic timerPinOut,
   output logic timerPinOe_n,
   input wire logic timer1Overflow,
   output logic overflowPulse,
   output logic txBitTick,
   output logic rxBitTick,
   output logic serviceRequest
);
   import reload_timer_pkg::*;

   // Refuse an address bus too narrow for the map
   if (ADDR_W < 4) begin : g_check
      $error("ADDR_W must be at least 4");
   end

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic overflowFlag;
      logic externalFlag;
      logic rxClockSelect;
      logic txClockSelect;
      logic externalPinEnable;
      logic runControl;
      logic counterSelect;
      logic downCountEnable;
      logic clockOutEnable;
      logic [1:0] countModeField;
      logic dirPinPrev;
      logic timerPinPrev;
      logic pinLevel;
      logic ovfPulse;
      logic [31:0] rdata;
   } timer_state_s;

   timer_state_s cur;
   timer_state_s nxt;

   // Address decode shared by read and write paths
   function automatic reg_sel_e regSelect(input logic [ADDR_W-1:0] a);
      logic [7:0] low;
      low = 8'(a);
      if (a[ADDR_W-1:0] != ADDR_W'(low)) begin
         regSelect = SEL_NONE;
      end else if (low == CTRL_OFFSET) begin
         regSelect = SEL_CTRL;
      end else if (low == MODE_OFFSET) begin
         regSelect = SEL_MODE;
      end else if (low == COUNT_OFFSET) begin
         regSelect = SEL_COUNT;
      end else if (low == RELOAD_OFFSET) begin
         regSelect = SEL_RELOAD;
      end else begin
         regSelect = SEL_NONE;
      end
   endfunction

   reg_sel_e sel;
   logic wrAccess;
   logic wrCtrl;
   logic wrMode;
   logic wrCount;
   logic wrReload;
   logic baudMode;
   logic udMode;
   logic clockOutMode;
   logic extFall;
   logic pinFall;
   logic tick;
   logic countUp;
   logic atLimit;
   logic rollover;
   logic extReload;
   logic extSet;

   // Bus strobes; zero wait states
   assign sel = regSelect(paddr);
   assign wrAccess = psel & penable & pwrite;
   assign wrCtrl = wrAccess & (sel == SEL_CTRL);
   assign wrMode = wrAccess & (sel == SEL_MODE);
   assign wrCount = wrAccess & (sel == SEL_COUNT);
   assign wrReload = wrAccess & (sel == SEL_RELOAD);
   assign pready = 1'b1;
   assign pslverr = psel & penable & (sel == SEL_NONE);

   // Operating modes; baud and clock-out are independent terms
   assign baudMode = cur.txClockSelect | cur.rxClockSelect; // RULE5
   assign clockOutMode = !cur.counterSelect & cur.clockOutEnable; // RULE14
   assign udMode = cur.downCountEnable & cur.externalPinEnable & !baudMode;

   // Edges from the previous sample, inputs already synchronous
   assign extFall = cur.dirPinPrev & !directionTriggerPin; // RULE20
   assign pinFall = cur.timerPinPrev & !timerPinIn; // RULE20

   // Count source: every clock, or falling pin edges in counter mode
   assign tick = cur.runControl & (cur.counterSelect ? pinFall : 1'b1); // RULE8 RULE15 RULE17
   assign countUp = !udMode | directionTriggerPin; // RULE1
   assign atLimit = countUp ? (cur.count == COUNT_MAX) : (cur.count == cur.reload); // RULE3
   assign rollover = tick & atLimit;

   // Pin edge reloads only in plain auto-reload; direction pin in up/down mode, flag in both auto-reload and baud mode
   assign extReload = cur.externalPinEnable & extFall & !baudMode & !udMode;
   assign extSet = cur.externalPinEnable & extFall & !udMode; // RULE10

   // Next state: software writes first, hardware events on top except for the count
   always_comb begin
      nxt = cur;
      nxt.dirPinPrev = directionTriggerPin;
      nxt.timerPinPrev = timerPinIn;
      nxt.ovfPulse = rollover;
      if (wrCtrl) begin
         nxt.overflowFlag = pwdata[CTL_OVF_FLAG];
         nxt.externalFlag = pwdata[CTL_EXT_FLAG]; // RULE18
         nxt.rxClockSelect = pwdata[CTL_RX_SEL];
         nxt.txClockSelect = pwdata[CTL_TX_SEL];
         nxt.externalPinEnable = pwdata[CTL_EXT_ENABLE];
         nxt.runControl = pwdata[CTL_RUN];
         nxt.counterSelect = pwdata[CTL_COUNTER_SEL];
      end
      if (wrMode) begin
         nxt.downCountEnable = pwdata[MOD_DOWN_ENABLE];
         nxt.clockOutEnable = pwdata[MOD_CLKOUT_ENABLE];
         nxt.countModeField = pwdata[MOD_CMODE_LSB+1:MOD_CMODE_LSB];
      end
      if (wrReload) begin
         nxt.reload = pwdata[15:0];
      end
      // Counter path; a software write to the count takes priority
      if (wrCount) begin
         nxt.count = pwdata[15:0];
      end else if (extReload) begin
         nxt.count = cur.reload;
      end else if (tick) begin
         if (rollover) begin
            nxt.count = countUp ? cur.reload : COUNT_MAX; // RULE2 RULE3 RULE5
         end else if (countUp) begin
            nxt.count = cur.count + 16'h0001; // RULE1
         end else begin
            nxt.count = cur.count - 16'h0001; // RULE1
         end
      end
      // Flags: a hardware set beats a software clear in the same cycle
      if (rollover & !baudMode) begin
         nxt.overflowFlag = 1'b1; // RULE2 RULE9
      end
      if (udMode & rollover) begin
         nxt.externalFlag = !cur.externalFlag; // RULE4
      end else if (extSet) begin
         nxt.externalFlag = 1'b1; // RULE10
      end
      // Half period per rollover gives a square wave
      if (clockOutMode & rollover) begin
         nxt.pinLevel = !cur.pinLevel; // RULE11 RULE12
      end
      // Read data captured in the setup cycle, valid through access
      if (psel & !penable & !pwrite) begin
         if (sel == SEL_CTRL) begin
            nxt.rdata = {24'h000000, cur.overflowFlag, cur.externalFlag, cur.rxClockSelect,
                         cur.txClockSelect, cur.externalPinEnable, cur.runControl,
                         cur.counterSelect, 1'b0};
         end else if (sel == SEL_MODE) begin
            nxt.rdata = {28'h0000000, cur.countModeField, cur.clockOutEnable, cur.downCountEnable};
         end else if (sel == SEL_COUNT) begin
            nxt.rdata = {16'h0000, cur.count};
         end else if (sel == SEL_RELOAD) begin
            nxt.rdata = {16'h0000, cur.reload};
         end else begin
            nxt.rdata = 32'h00000000;
         end
      end
   end

   // State register; all control bits clear at reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur.count <= COUNT_RESET;
         cur.reload <= RELOAD_RESET;
         {cur.overflowFlag, cur.externalFlag, cur.rxClockSelect, cur.txClockSelect,
          cur.externalPinEnable, cur.runControl, cur.counterSelect} <= CTRL_RESET[7:1];
         cur.downCountEnable <= MODE_RESET[MOD_DOWN_ENABLE]; // RULE19
         cur.clockOutEnable <= MODE_RESET[MOD_CLKOUT_ENABLE];
         cur.countModeField <= CMODE_RESET;
         cur.dirPinPrev <= 1'b0;
         cur.timerPinPrev <= 1'b0;
         cur.pinLevel <= 1'b0;
         cur.ovfPulse <= 1'b0;
         cur.rdata <= 32'h00000000;
      end else begin
         cur <= nxt;
      end
   end

   // Pin drives only in clock-out mode; counter mode leaves it an input
   assign timerPinOut = cur.pinLevel;
   assign timerPinOe_n = !clockOutMode; // RULE16
   assign prdata = cur.rdata;
   assign overflowPulse = cur.ovfPulse;
   // Overflow request gated off in baud and clock-out modes, external flag request off in up/down mode
   assign serviceRequest = (cur.overflowFlag & !baudMode & !clockOutMode) // RULE9 RULE13
                         | (cur.externalFlag & !udMode); // RULE4

   // Serial bit ticks from this timer or the other timer
   baud_tick_divider #(
      .DIVIDE(BAUD_DIVIDE)
   ) u_baud (
      .mclk(mclk),
      .rst_n(rst_n),
      .ownOverflow(cur.ovfPulse),
      .otherOverflow(timer1Overflow),
      .txSelect(cur.txClockSelect),
      .rxSelect(cur.rxClockSelect),
      .txBitTick(txBitTick),
      .rxBitTick(rxBitTick)
   );

   chk_up_reload: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
      (rollover && countUp && !wrCount && !extReload) |=> (cur.count == $past(cur.reload)))
      else $error("up rollover did not reload");

   chk_down_underflow: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
      (rollover && !countUp && !wrCount) |=> (cur.count == COUNT_MAX && cur.overflowFlag))
      else $error("down underflow did not load max");

   chk_dir_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
      (udMode && tick && !directionTriggerPin && !rollover && !wrCount)
      |=> (cur.count == $past(cur.count) - 16'h0001))
      else $error("low direction pin did not count down");

   chk_ext_toggle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
      (udMode && rollover) |=> (cur.externalFlag != $past(cur.externalFlag)))
      else $error("external flag did not toggle");

   chk_baud_no_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
      (baudMode && !cur.overflowFlag && !wrCtrl) |=> !cur.overflowFlag)
      else $error("overflow flag set in baud mode");

   chk_baud_ext_edge: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
      (baudMode && extSet && !wrCount && !rollover)
      |=> (cur.externalFlag && cur.count == $past(cur.count) + {15'h0000, $past(tick)}))
      else $error("baud mode pin edge misbehaved");

   chk_pin_toggle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
      (clockOutMode && rollover && !wrCtrl && !wrMode)
      |=> (cur.pinLevel != $past(cur.pinLevel) && !timerPinOe_n))
      else $error("clock-out pin did not toggle");

   chk_stop_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
      (!cur.runControl && !wrCount && !extReload) |=> $stable(cur.count))
      else $error("count moved while stopped");

   chk_counter_edges: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
      (cur.counterSelect && !pinFall && !wrCount && !extReload) |=> $stable(cur.count))
      else $error("counter mode moved without pin edge");

endmodule

// ===== pkg/reload_timer_pkg.sv
// Purpose: shared constants for the reload timer with baud and clock-out support
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: control and mode bit positions are grouped by register
package reload_timer_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] MODE_OFFSET = 8'h04;
   localparam logic [7:0] COUNT_OFFSET = 8'h08;
   localparam logic [7:0] RELOAD_OFFSET = 8'h0C;

   // Control register bit positions
   localparam int CTL_COUNTER_SEL = 1;
   localparam int CTL_RUN = 2;
   localparam int CTL_EXT_ENABLE = 3;
   localparam int CTL_TX_SEL = 4;
   localparam int CTL_RX_SEL = 5;
   localparam int CTL_EXT_FLAG = 6;
   localparam int CTL_OVF_FLAG = 7;

   // Mode register bit positions
   localparam int MOD_DOWN_ENABLE = 0;
   localparam int MOD_CLKOUT_ENABLE = 1;
   localparam int MOD_CMODE_LSB = 2;

   // Values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [1:0] CMODE_RESET = 2'h0;

   // Counter limits and serial divide
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] CMODE_UP_DOWN = 2'h0;
   localparam int BAUD_DIVIDE = 16;

   // Register select codes
   typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_MODE, SEL_COUNT, SEL_RELOAD} reg_sel_e;

endpackage

// ===== hw/baud_tick_divider.sv
// Purpose: turn timer overflow pulses into serial transmit and receive bit ticks
// Assumes: overflow inputs are one-cycle pulses in the mclk domain
// Notes: each direction picks its own source and divides it separately
`timescale 1ns/100ps
module baud_tick_divider #(
   parameter int DIVIDE = reload_timer_pkg::BAUD_DIVIDE
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ownOverflow,
   input wire logic otherOverflow,
   input wire logic txSelect,
   input wire logic rxSelect,
   output logic txBitTick,
   output logic rxBitTick
);
   import reload_timer_pkg::*;

   localparam int CW = $clog2(DIVIDE);
   localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

   // Refuse a divide that cannot make a tick
   if (DIVIDE < 2) begin : g_check
      $error("DIVIDE must be at least 2");
   end

   typedef struct packed {
      logic [1:0][CW-1:0] phase;
      logic [1:0] tick;
   } div_state_s;

   div_state_s cur;
   div_state_s nxt;
   logic [1:0] srcPulse;

   // Channel 0 transmit, channel 1 receive, chosen independently
   assign srcPulse[0] = txSelect ? ownOverflow : otherOverflow; // RULE6
   assign srcPulse[1] = rxSelect ? ownOverflow : otherOverflow; // RULE6

   // One tick per DIVIDE source pulses
   always_comb begin
      nxt = cur;
      for (int i = 0; i < 2; i++) begin
         nxt.tick[i] = 1'b0;
         if (srcPulse[i]) begin
            if (cur.phase[i] == LAST) begin
               nxt.phase[i] = '0; // RULE7
               nxt.tick[i] = 1'b1; // RULE7
            end else begin
               nxt.phase[i] = cur.phase[i] + CW'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign txBitTick = cur.tick[0];
   assign rxBitTick = cur.tick[1];

   // Sources pulse at most once a cycle, so ticks stand well apart
   chk_tx_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
      txBitTick |=> !txBitTick [*8]) else $error("transmit ticks closer than the divide");

endmodule

// ===== tb/serial_port_model.sv
// Purpose: serial port stand-in on the far side of the timer's tick outputs
// Assumes: one mclk domain, ticks are one-cycle pulses
// Notes: the other timer free-runs so a port direction can use it instead
`timescale 1ns/100ps
module serial_port_model #(
   parameter int OTHER_PERIOD = 20
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic txBitTick,
   input wire logic rxBitTick,
   output logic timer1Overflow
);
   int divCount;
   int txBits;
   int rxBits;
   // Other timer: one pulse every OTHER_PERIOD cycles, never stalls
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divCount <= 0;
         timer1Overflow <= 1'b0;
      end else begin
         divCount <= (divCount == OTHER_PERIOD - 1) ? 0 : divCount + 1;
         timer1Overflow <= (divCount == OTHER_PERIOD - 1);
      end
   end
   // Bit clocks consumed one per tick, each direction on its own
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txBits <= 0;
         rxBits <= 0;
      end else begin
         txBits <= txBits + int'(txBitTick);
         rxBits <= rxBits + int'(rxBitTick);
      end
   end
endmodule

// ===== tb/reload_timer_baud_clockout_tb_top.sv
// Purpose: self-checking bench for the reload timer over APB and its pins
// Assumes: zero-wait APB slave, pins synchronous to mclk
// Notes: periods are measured rise to rise after the design settles
`timescale 1ns/100ps
module reload_timer_baud_clockout_tb_top;
   import reload_timer_pkg::*;
   localparam logic [31:0] RUN = 32'h1 << CTL_RUN;
   localparam logic [31:0] EXTEN = 32'h1 << CTL_EXT_ENABLE;
   localparam logic [31:0] TXS = 32'h1 << CTL_TX_SEL;
   localparam logic [31:0] CSEL = 32'h1 << CTL_COUNTER_SEL;
   localparam logic [31:0] OVF = 32'h1 << CTL_OVF_FLAG;
   localparam logic [31:0] EXTF = 32'h1 << CTL_EXT_FLAG;
   localparam logic [31:0] DOWN = 32'h1 << MOD_DOWN_ENABLE;
   localparam logic [31:0] CLKO = 32'h1 << MOD_CLKOUT_ENABLE;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, c1;
   logic directionTriggerPin, timerPinIn, timerPinOut, timerPinOe_n, timer1Overflow;
   logic overflowPulse, txBitTick, rxBitTick, serviceRequest, se;
   int errCount, cmpCount, cycles, n;

   reload_timer #(.ADDR_W(8)) dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .directionTriggerPin(directionTriggerPin), .timerPinIn(timerPinIn),
      .timerPinOut(timerPinOut), .timerPinOe_n(timerPinOe_n), .timer1Overflow(timer1Overflow),
      .overflowPulse(overflowPulse), .txBitTick(txBitTick), .rxBitTick(rxBitTick),
      .serviceRequest(serviceRequest));
   serial_port_model #(.OTHER_PERIOD(20)) port (.mclk(mclk), .rst_n(rst_n), .txBitTick(txBitTick),
      .rxBitTick(rxBitTick), .timer1Overflow(timer1Overflow));

   // Clock at 40 MHz
   always #12.5 mclk = ~mclk;
   // Hang guard, far above the longest expected run
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errCount++;
         results();
      end
   end

   task automatic results;
      if (errCount == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmpCount++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // No wait limit here; the hang guard ends a stuck transfer
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return overflowPulse;
         1: return txBitTick;
         2: return rxBitTick;
         default: return timerPinOut;
      endcase
   endfunction
   // Waits for the next rise; n+1 is the period when called just after a rise
   task automatic rise(input int s, output int k);
      k = 0;
      #1;
      while (sig(s) === 1'b1 && k < 9000) begin
         @(posedge mclk);
         #1;
         k++;
      end
      while (sig(s) !== 1'b1 && k < 9000) begin
         @(posedge mclk);
         #1;
         k++;
      end
      @(posedge mclk);
   endtask
   task automatic per(input int s, input int exp, input string msg);
      rise(s, n);
      rise(s, n);
      chk(32'(n + 1), 32'(exp), msg);
   endtask

   task automatic t_reset;
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, 32'(CTRL_RESET), "ctrl reset");
      apb(1'b0, MODE_OFFSET, 32'h0);
      chk(rd, 32'(MODE_RESET), "mode reset");
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, se}, 32'h1, "unmapped error");
   endtask
   task automatic t_up;
      apb(1'b1, RELOAD_OFFSET, 32'hFFF0);
      apb(1'b1, COUNT_OFFSET, 32'hFFF0);
      apb(1'b1, CTRL_OFFSET, RUN);
      per(0, 16, "up period");
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd & OVF, OVF, "overflow flag");
      chk({31'h0, serviceRequest}, 32'h1, "overflow request");
   endtask
   task automatic t_updown;
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b1, MODE_OFFSET, DOWN);
      apb(1'b1, RELOAD_OFFSET, 32'h1000);
      apb(1'b1, COUNT_OFFSET, 32'h8000);
      directionTriggerPin <= 1'b1;
      apb(1'b1, CTRL_OFFSET, RUN | EXTEN);
      apb(1'b0, COUNT_OFFSET, 32'h0);
      c1 = rd;
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk(rd - c1, 32'h3, "count up");
      directionTriggerPin <= 1'b0;
      apb(1'b0, COUNT_OFFSET, 32'h0);
      c1 = rd;
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk(c1 - rd, 32'h3, "count down");
      apb(1'b1, RELOAD_OFFSET, 32'hFFF0);
      // Start near the reload value, else the first underflow is far off
      apb(1'b1, COUNT_OFFSET, 32'hFFF8);
      per(0, 16, "underflow period");
      apb(1'b0, CTRL_OFFSET, 32'h0);
      c1 = rd;
      rise(0, n);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk((rd ^ c1) & EXTF, EXTF, "seventeenth bit");
      apb(1'b1, CTRL_OFFSET, EXTEN | EXTF);
      chk({31'h0, serviceRequest}, 32'h0, "up/down flag silent");
      apb(1'b1, MODE_OFFSET, 32'h0);
      chk({31'h0, serviceRequest}, 32'h1, "flag requests otherwise");
   endtask
   task automatic t_baud;
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b1, COUNT_OFFSET, 32'hFFF0);
      apb(1'b1, CTRL_OFFSET, RUN | TXS | EXTEN);
      per(1, 16 * 16, "tx tick period");
      per(2, 16 * 20, "rx from other timer");
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd & OVF, 32'h0, "no flag in baud");
      chk({31'h0, serviceRequest}, 32'h0, "no request in baud");
      // Stopped, off the reload value, so a wrong reload would show
      apb(1'b1, CTRL_OFFSET, TXS | EXTEN);
      apb(1'b1, COUNT_OFFSET, 32'hFFF8);
      directionTriggerPin <= 1'b1;
      repeat (2) @(posedge mclk);
      directionTriggerPin <= 1'b0;
      repeat (2) @(posedge mclk);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd & EXTF, EXTF, "edge flag in baud");
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk(rd, 32'hFFF8, "no reload on edge in baud");
   endtask
   task automatic t_clkout;
      apb(1'b1, MODE_OFFSET, CLKO);
      apb(1'b1, CTRL_OFFSET, RUN | TXS);
      chk({31'h0, timerPinOe_n}, 32'h0, "pin driven");
      per(3, 32, "clock out period");
      per(1, 256, "baud alongside");
      apb(1'b1, CTRL_OFFSET, RUN);
      rise(0, n);
      chk({31'h0, serviceRequest}, 32'h0, "clock out silent");
   endtask
   task automatic t_stop_counter;
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b0, COUNT_OFFSET, 32'h0);
      c1 = rd;
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk(rd, c1, "stopped");
      apb(1'b1, COUNT_OFFSET, 32'h0);
      apb(1'b1, CTRL_OFFSET, CSEL | RUN);
      chk({31'h0, timerPinOe_n}, 32'h1, "pin is input");
      repeat (5) begin
         timerPinIn <= 1'b0;
         repeat (2) @(posedge mclk);
         timerPinIn <= 1'b1;
         repeat (2) @(posedge mclk);
      end
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk(rd, 32'h5, "pin edges counted");
   endtask

   // Main sequence
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      directionTriggerPin = 1'b0;
      timerPinIn = 1'b1;
      errCount = 0;
      cmpCount = 0;
      cycles = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_up();
      t_updown();
      t_baud();
      t_clkout();
      t_stop_counter();
      results();
   end
endmodule
